// >>> bench/swl_host.sv
// Host model driving the serial link of the wiper latch loader
`timescale 1ns/10ps
`default_nettype none
module swl_host (
    output logic        link_clk,
    output logic        cs_n,
    output logic        serial_in_pin,
    input  wire logic   chain_line,
    output logic [19:0] seen
);
    initial begin
        link_clk = 1'b0;
        cs_n = 1'b1;
        serial_in_pin = 1'b0;
        seen = 20'h00000;
    end
    // Clock stands still between frames; idle data flips to expose stale use
    task automatic send(input logic [19:0] bits, input int n);
        cs_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin // Address then code, MSB
            serial_in_pin = bits[i];
            #6 link_clk = 1'b1;
            #6 link_clk = 1'b0;
            seen = {seen[18:0], chain_line};
        end
        #3 cs_n = 1'b1; // Whole words, zero unused address bits
        serial_in_pin = ~serial_in_pin;
        #40;
    endtask
endmodule // swl_host
`default_nettype wire

// >>> bench/tb_swl_loader.sv
// Self-checking bench for the serial wiper latch loader
`timescale 1ns/10ps
`default_nettype none
module tb_serial_wiper_latch_loader;
    logic        sys_clk = 1'b0;
    logic        resetn, midscale_reset_n, power_down_n;
    logic        link_clk, cs_n, serial_in_pin;
    logic        chain_out_pin_o, chain_out_pin_oe;
    logic [15:0] latch_two;
    logic [31:0] wiper_latch, wiper_tap, exp_l;
    logic [3:0]  term_a_open, wiper_to_b;
    logic [19:0] seen;
    int          n_fail = 0, checked = 0, cycles = 0;
    // Pull-up on the open-drain chain line
    wire chain_line = chain_out_pin_oe ? chain_out_pin_o : 1'b1;
    always #5 sys_clk = ~sys_clk;
    swl_loader #(.N_CH(4)) u_dut (.sys_clk(sys_clk), .resetn(resetn),
        .clk_en(1'b1), .link_clk(link_clk), .cs_n(cs_n),
        .serial_in_pin(serial_in_pin), .midscale_reset_n(midscale_reset_n),
        .power_down_n(power_down_n), .chain_out_pin_o(chain_out_pin_o),
        .chain_out_pin_oe(chain_out_pin_oe), .wiper_latch(wiper_latch),
        .wiper_tap(wiper_tap), .term_a_open(term_a_open),
        .wiper_to_b(wiper_to_b));
    swl_host u_host (.link_clk(link_clk), .cs_n(cs_n),
        .serial_in_pin(serial_in_pin), .chain_line(chain_line), .seen(seen));
    // Two-channel variant sees every word, so top addresses must be ignored
    swl_loader #(.N_CH(2)) u_dut_two (.sys_clk(sys_clk), .resetn(resetn),
        .clk_en(1'b1), .link_clk(link_clk), .cs_n(cs_n),
        .serial_in_pin(serial_in_pin), .midscale_reset_n(midscale_reset_n),
        .power_down_n(power_down_n), .chain_out_pin_o(),
        .chain_out_pin_oe(), .wiper_latch(latch_two), .wiper_tap(),
        .term_a_open(), .wiper_to_b());
    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic results();
        if (n_fail == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            n_fail++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic settle();
        repeat (6) @(negedge sys_clk);
    endtask
    task automatic write(input logic [1:0] ch, input logic [7:0] code);
        u_host.send({10'h000, ch, code}, 10);
        settle();
        exp_l[ch*8+:8] = code;
        check(wiper_latch, exp_l);
        check({16'h0, latch_two}, {16'h0, exp_l[15:0]});
    endtask
    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_reset();
        check(wiper_latch, 32'h80808080);
        check({16'h0, latch_two}, 32'h00008080);
        check({28'h0, term_a_open}, 32'h0);
    endtask
    task automatic t_channels();
        logic [7:0] codes[4] = '{8'ha5, 8'h7f, 8'h00, 8'hff};
        for (int c = 3; c >= 0; c--) begin
            write(c[1:0], codes[c]);
            settle();
            check(wiper_tap, exp_l);
        end
    endtask
    task automatic t_daisy();
        logic [19:0] w = {10'h3c3, 2'b01, 8'h5a};
        u_host.send(w, 20);
        settle();
        exp_l[15:8] = 8'h5a;
        check(wiper_latch, exp_l);
        check({21'h0, seen[10:0]}, {21'h0, w[19:9]});
    endtask
    task automatic t_shutdown();
        power_down_n = 1'b0;
        settle();
        check({24'h0, term_a_open, wiper_to_b}, 32'hff);
        check(wiper_tap, 32'h0);
        u_host.send({10'h000, 2'b10, 8'h3c}, 20);
        settle();
        check({21'h0, seen[10:0]}, 32'h7ff);
        exp_l[23:16] = 8'h3c;
        check(wiper_latch, exp_l);
        check({16'h0, latch_two}, {16'h0, exp_l[15:0]});
        power_down_n = 1'b1;
        settle();
        check(wiper_tap, exp_l);
        check({28'h0, term_a_open}, 32'h0);
    endtask
    task automatic t_midscale();
        write(2'b11, 8'hff);
        midscale_reset_n = 1'b0;
        settle();
        check(wiper_latch, 32'h80808080);
        midscale_reset_n = 1'b1;
        settle();
        exp_l = 32'h80808080;
        write(2'b00, 8'h42);
        // Cleared serial register keeps the chain line low early on
        check({23'h0, seen[9:1]}, 32'h0);
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            results();
        end
    end
    initial begin
        resetn = 1'b0;
        midscale_reset_n = 1'b1;
        power_down_n = 1'b1;
        exp_l = 32'h80808080;
        repeat (16) @(negedge sys_clk);
        resetn = 1'b1;
        repeat (4) @(negedge sys_clk);
        t_reset();
        t_channels();
        t_daisy();
        t_shutdown();
        t_midscale();
        results();
    end
endmodule // tb_serial_wiper_latch_loader
`default_nettype wire

// >>> design/swl_loader.sv
// Serial wiper latch loader: shift register, decode and wiper latches
`timescale 1ns/10ps
`default_nettype none
// Function
// - Ten-bit word shifts into serial register
// - Two address bits, then eight code bits
// - Channel equals high*2 plus low plus one
// - One word updates at most one latch; unimplemented addresses update none
// - Latch code selects one of 256 taps
// - Latch content undefined before any reset
// - Midscale reset forces every latch midscale
// - Shutdown opens A, wiper to B
// - Shutdown keeps latches, release restores positions
// - Shutdown keeps interface, disables chain output
// - Writes during shutdown apply after release
// - Shift on rising clock; tenth bit out
// - Chip select rise loads addressed latch
// - Midscale reset loads 80, clears chain output
module swl_loader
    import swl_pkg::*;
#(
    parameter int N_CH = MAX_CH
) (
    input  wire logic                  sys_clk,
    input  wire logic                  resetn,
    input  wire logic                  clk_en,
    input  wire logic                  link_clk,
    input  wire logic                  cs_n,
    input  wire logic                  serial_in_pin,
    input  wire logic                  midscale_reset_n,
    input  wire logic                  power_down_n,
    output logic                       chain_out_pin_o,
    output logic                       chain_out_pin_oe,
    output logic [N_CH*CODE_BITS-1:0]  wiper_latch,
    output logic [N_CH*CODE_BITS-1:0]  wiper_tap,
    output logic [N_CH-1:0]            term_a_open,
    output logic [N_CH-1:0]            wiper_to_b
);

    // ************************************************************
    // Link domain: serial input register
    // ************************************************************
    logic                  link_rst_n;
    logic [WORD_BITS-1:0]  sr_q;
    logic [WORD_BITS-1:0]  sr_d;
    logic                  pd_act;

    // Midscale pin also clears the register, even with no link clock
    assign link_rst_n = resetn & midscale_reset_n;

    always_comb begin
        sr_d = sr_q;
        if (!cs_n) begin
            sr_d = {sr_q[WORD_BITS-2:0], serial_in_pin};
        end
    end

    always_ff @(posedge link_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            sr_q <= SR_RESET;
        end else begin
            sr_q <= sr_d;
        end
    end

    // Open drain: pull low only for a zero bit, never in shutdown
    assign chain_out_pin_o  = 1'b0;
    assign chain_out_pin_oe = !sr_q[WORD_BITS-1] && !cs_n
                              && !pd_act;

    // ************************************************************
    // System domain: pin synchronisers
    // ************************************************************
    logic [2:0]  sync1_q;
    logic [2:0]  sync1_d;
    logic [2:0]  sync2_q;
    logic [2:0]  sync2_d;
    logic        cs_prev_q;
    logic        cs_prev_d;
    logic        load;
    logic        mid_act;

    always_comb begin
        sync1_d   = {power_down_n, midscale_reset_n, cs_n};
        sync2_d   = sync1_q;
        cs_prev_d = sync2_q[PIN_CS];
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            sync1_q   <= PIN_IDLE;
            sync2_q   <= PIN_IDLE;
            cs_prev_q <= 1'b1;
        end else if (clk_en) begin
            sync1_q   <= sync1_d;
            sync2_q   <= sync2_d;
            cs_prev_q <= cs_prev_d;
        end
    end

    // Word is static once select is high, so it may be read here
    assign load    = sync2_q[PIN_CS] && !cs_prev_q;
    assign mid_act = !sync2_q[PIN_MID];
    assign pd_act  = !sync2_q[PIN_PD];

    // ************************************************************
    // System domain: wiper latches
    // ************************************************************
    logic [N_CH*CODE_BITS-1:0]  latch_q;
    logic [N_CH*CODE_BITS-1:0]  latch_d;
    logic [ADDR_BITS-1:0]       word_addr;
    logic [CODE_BITS-1:0]       word_code;

    assign word_addr = sr_q[ADDR_LSB +: ADDR_BITS];
    assign word_code = sr_q[CODE_LSB +: CODE_BITS];

    always_comb begin
        latch_d = latch_q;
        if (mid_act) begin
            latch_d = {N_CH{MIDSCALE}};
        end else if (load && swl_chan_ok(word_addr, N_CH)) begin
            // Only the addressed slice moves; others
            latch_d[int'(word_addr)*CODE_BITS +: CODE_BITS] =
                word_code;
        end
    end

    // System reset gives a defined value; the part itself need not
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            latch_q <= {N_CH{MIDSCALE}};
        end else if (clk_en) begin
            latch_q <= latch_d;
        end
    end

    // ************************************************************
    // System domain: terminal control outputs
    // ************************************************************
    logic [N_CH*CODE_BITS-1:0]  tap_q;
    logic [N_CH*CODE_BITS-1:0]  tap_d;
    logic [N_CH-1:0]            open_q;
    logic [N_CH-1:0]            open_d;

    always_comb begin
        tap_d  = latch_q;
        open_d = {N_CH{pd_act}};
        if (pd_act) begin
            tap_d = '0;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            tap_q  <= {N_CH{MIDSCALE}};
            open_q <= '0;
        end else if (clk_en) begin
            tap_q  <= tap_d;
            open_q <= open_d;
        end
    end

    assign wiper_latch = latch_q;
    assign wiper_tap   = tap_q;
    assign term_a_open = open_q;
    assign wiper_to_b  = open_q;

    // ************************************************************
    // Assertions
    // ************************************************************
    // Checker helper: set by a frame's first link edge.
    // Select or reset clears it, so a clear between frames
    // is never mistaken for a shift.
    logic  frame_clr;
    logic  in_frame_q;
    logic  in_frame_d;

    assign frame_clr = cs_n || !link_rst_n;

    always_comb begin
        in_frame_d = 1'b1;
    end

    always_ff @(posedge link_clk or posedge frame_clr) begin
        if (frame_clr) begin
            in_frame_q <= 1'b0;
        end else begin
            in_frame_q <= in_frame_d;
        end
    end

    sequence s_sel_rise;
        clk_en && load && !mid_act;
    endsequence

    sequence s_pd_fall;
        clk_en && !pd_act && $past(pd_act);
    endsequence

    property p_shift;
        @(posedge link_clk) disable iff (!link_rst_n)
        in_frame_q |-> sr_q == {$past(sr_q[WORD_BITS-2:0]),
                                $past(serial_in_pin)};
    endproperty

    a_shift_one_bit: assert property (p_shift)
        else $error("serial register did not shift one bit");

    // Word crosses to the system side unsynchronised: it must sit still
    // for as long as select stays high
    a_idle_hold: assert property (
        @(posedge sys_clk) disable iff (!link_rst_n)
        cs_n && $past(cs_n) && $past(link_rst_n) |-> $stable(sr_q))
        else $error("serial register moved while deselected");

    // Shutdown pin held through both sync stages turns the line off
    a_chain_off_pd: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        (clk_en && !power_down_n) [*3] |-> !chain_out_pin_oe)
        else $error("chain output driven in shutdown");

    // Pin to latch: two sync stages, then the load edge
    a_mid_all: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        (clk_en && !midscale_reset_n) [*3] |=>
        latch_q == {N_CH{MIDSCALE}})
        else $error("midscale reset did not load 80");

    a_load_target: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        s_sel_rise ##0 swl_chan_ok(word_addr, N_CH) |=>
        latch_q[int'($past(word_addr))*CODE_BITS +: CODE_BITS]
            == $past(word_code))
        else $error("addressed latch not loaded");

    a_load_one_only: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        s_sel_rise ##0 (word_addr != 2'h0) |=>
        latch_q[CODE_BITS-1:0] == $past(latch_q[CODE_BITS-1:0]))
        else $error("a second latch changed on one load");

    a_unimpl_ignore: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        s_sel_rise ##0 !swl_chan_ok(word_addr, N_CH) |=>
        $stable(latch_q))
        else $error("unimplemented address changed a latch");

    a_pd_terms: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        clk_en && pd_act |=> tap_q == '0 && open_q == '1)
        else $error("shutdown did not open A and tie wiper to B");

    a_pd_keep: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        clk_en && pd_act && !load && !mid_act |=> $stable(latch_q))
        else $error("shutdown altered a latch");

    a_pd_resume: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        s_pd_fall ##1 clk_en |-> tap_q == latch_q && open_q == '0)
        else $error("release did not restore latch positions");

    // Select rise as sampled by the first sync stage
    sequence s_cs_seen;
        clk_en && $rose(cs_n);
    endsequence

    // Second sync stage, then the load edge itself
    sequence s_sync_wait;
        clk_en ##1 (clk_en && !mid_act);
    endsequence

    // Whole path from the select pin; select must stay high meanwhile
    property p_load_latency;
        @(posedge sys_clk) disable iff (!resetn)
        s_cs_seen ##0 swl_chan_ok(word_addr, N_CH) ##1 s_sync_wait
        |=> latch_q[int'(word_addr)*CODE_BITS +: CODE_BITS] == word_code;
    endproperty

    a_load_latency: assert property (p_load_latency)
        else $error("latch not loaded three edges after select rise");

    // Latches move only on a load or a midscale reset
    a_latch_quiet: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        clk_en && !load && !mid_act |=> $stable(latch_q))
        else $error("latch changed with no load");

    a_tap_follow: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        clk_en && !pd_act |=> tap_q == $past(latch_q))
        else $error("tap does not follow latch code");

    a_open_idle: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        clk_en && !pd_act |=> open_q == '0)
        else $error("A terminal open outside shutdown");

    // Clear is asynchronous, so it holds even with the link clock stopped
    a_mid_clear_sr: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        !midscale_reset_n |-> sr_q == SR_RESET)
        else $error("midscale reset did not clear serial register");

endmodule // swl_loader
`default_nettype wire

// >>> design/swl_pkg.sv
// Constants and helpers for the serial wiper latch loader
package swl_pkg;

    // ************************************************************
    // Serial word layout
    // ************************************************************
    localparam int WORD_BITS   = 10;
    localparam int ADDR_BITS   = 2;
    localparam int CODE_BITS   = 8;
    localparam int ADDR_LSB    = 8;
    localparam int CODE_LSB    = 0;
    localparam int MAX_CH      = 4;

    // ************************************************************
    // Reset values and synchroniser layout
    // ************************************************************
    localparam logic [7:0] MIDSCALE    = 8'h80;
    localparam logic [9:0] SR_RESET    = 10'h000;
    localparam logic [2:0] PIN_IDLE    = 3'h7;
    localparam int         PIN_CS      = 0;
    localparam int         PIN_MID     = 1;
    localparam int         PIN_PD      = 2;

    // ************************************************************
    // Address decode
    // ************************************************************
    // Channel number is high bit times two plus low bit plus one
    function automatic logic [2:0] swl_chan_num(
        input logic [ADDR_BITS-1:0] addr
    );
        swl_chan_num = {1'b0, addr} + 3'h1;
    endfunction

    function automatic logic swl_chan_ok(
        input logic [ADDR_BITS-1:0] addr,
        input int                   n_ch
    );
        swl_chan_ok = (int'(swl_chan_num(addr)) <= n_ch);
    endfunction

endpackage
